/* File: inc/cise_pkg.sv */
`default_nettype none

package cise_pkg;

	// ==========================================================
	// Register map (byte addresses on the AXI4-Lite slave)
	// ==========================================================
	localparam int          CISE_AXI_AW      = 8;
	localparam logic [7:0]  CISE_OFF_CTRL    = 8'h00;
	localparam logic [7:0]  CISE_OFF_INSTR   = 8'h04;
	localparam logic [7:0]  CISE_OFF_PC      = 8'h08;
	localparam logic [7:0]  CISE_OFF_WREG    = 8'h0C;
	localparam logic [7:0]  CISE_OFF_FLAGS   = 8'h10;
	localparam logic [7:0]  CISE_OFF_BANK    = 8'h14;
	localparam logic [7:0]  CISE_OFF_TOS     = 8'h18;
	localparam logic [7:0]  CISE_OFF_IDXBASE = 8'h1C;
	localparam logic [7:0]  CISE_OFF_FADDR   = 8'h20;
	localparam logic [7:0]  CISE_OFF_FDATA   = 8'h24;
	localparam logic [7:0]  CISE_OFF_EXEC    = 8'h28;

	// ==========================================================
	// Field positions
	// ==========================================================
	localparam int          CISE_CTRL_EXT_BIT  = 0;
	localparam int          CISE_INSTR_TWO_BIT = 16;
	localparam int          CISE_FLAG_Z_BIT    = 0;
	localparam int          CISE_FLAG_N_BIT    = 1;
	localparam int          CISE_EXEC_BUSY_BIT = 0;
	localparam int          CISE_EXEC_CYC_LSB  = 1;
	localparam int          CISE_EXEC_OVF_BIT  = 3;
	localparam int          CISE_EXEC_DEP_LSB  = 4;

	// ==========================================================
	// Widths and reset values
	// ==========================================================
	localparam int          CISE_PC_W        = 21;
	localparam int          CISE_FADDR_W     = 12;
	localparam logic [20:0] CISE_PC_RST      = 21'h000000;
	localparam logic [7:0]  CISE_BYTE_RST    = 8'h00;
	localparam logic [3:0]  CISE_BANK_RST    = 4'h0;
	localparam logic [11:0] CISE_IDX_RST     = 12'h000;
	localparam logic        CISE_EXT_RST     = 1'b0;

	// ==========================================================
	// Opcodes and addressing constants
	// ==========================================================
	localparam logic [15:0] CISE_OP_RESET    = 16'h00FF;
	localparam logic [7:0]  CISE_OP_XORL     = 8'h0A;
	localparam logic [4:0]  CISE_OP_RELATIVE_SUBROUTINE_CALL    = 5'h1B;
	localparam logic [6:0]  CISE_OP_TSTFZ    = 7'h33;
	localparam logic [7:0]  CISE_OP_BNEG     = 8'hE6;
	localparam logic [3:0]  CISE_OP_BCLR     = 4'h9;
	localparam logic [7:0]  CISE_IDX_LIMIT   = 8'h5F;
	localparam logic [7:0]  CISE_ACC_SPLIT   = 8'h60;
	localparam logic [3:0]  CISE_ACC_HI_BANK = 4'hF;
	localparam logic [20:0] CISE_PC_STEP     = 21'h000002;
	localparam logic [1:0]  CISE_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  CISE_RESP_SLVERR = 2'h2;

	typedef enum logic [3:0] {
		CISE_Q1 = 4'b0001,
		CISE_Q2 = 4'b0010,
		CISE_Q3 = 4'b0100,
		CISE_Q4 = 4'b1000
	} cise_phase_e;

	typedef struct packed {
		logic        next_two;
		logic [15:0] word;
	} cise_instr_s;

endpackage

`default_nettype wire

/* File: logic/cise_core.sv */
// Behaviour
// - Relative call pushes PC plus two first
// - Relative call target is PC+2+2n, 11-bit n
// - Relative call takes two cycles, second idle
// - Reset opcode returns registers to reset values, except CTRL, INSTR and file memory
// - Zero operand skips next word, two cycles
// - Skipping two-word instruction takes three cycles
// - Access bit picks access bank or bank register
// - Extended set, low addresses become indexed offsets
// - Literal XOR into W, sets N and Z
// - Extended addressing only when config bit set
`timescale 1ns/1ps
`default_nettype none

module cise_core
	import cise_pkg::*;
#(
	parameter int STACK_DEPTH = 8
) (
	input  wire logic                   sys_clk_i,
	input  wire logic                   resetn_i,
	input  wire logic [CISE_AXI_AW-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [CISE_AXI_AW-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready
);
	import cise_pkg::*;

	// The depth counter is five bits wide, so deeper stacks cannot be tracked.
	if (STACK_DEPTH < 1 || STACK_DEPTH > 31) begin : g_bad_depth
		$error("cise_core: STACK_DEPTH must be 1 to 31");
	end

	function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	function automatic logic [11:0] file_addr(input logic acc, input logic [7:0] f, input logic [3:0] bank,
		input logic ext, input logic [11:0] base);
		logic [11:0] res;
		if (acc) begin
			res = {bank, f};
		end else if (ext && f <= CISE_IDX_LIMIT) begin
			res = base + {4'h0, f};
		end else if (f < CISE_ACC_SPLIT) begin
			res = {4'h0, f};
		end else begin
			res = {CISE_ACC_HI_BANK, f};
		end
		return res;
	endfunction

	// ==========================================================
	// AXI4-Lite slave
	// ==========================================================
	logic                   aw_hold_r;
	logic                   w_hold_r;
	logic [CISE_AXI_AW-1:0] awaddr_r;
	logic [31:0]            wdata_r;
	logic [3:0]             wstrb_r;
	logic                   bvalid_r;
	logic [1:0]             bresp_r;
	logic                   rvalid_r;
	logic [31:0]            rdata_r;
	logic [1:0]             rresp_r;
	logic                   wr_fire;
	logic [31:0]            wr_val;
	logic [31:0]            rd_val;
	logic                   rd_hit;
	logic                   wr_hit;

	assign s_axi_awready = !aw_hold_r && !bvalid_r;
	assign s_axi_wready  = !w_hold_r && !bvalid_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign wr_fire       = aw_hold_r && w_hold_r;
	assign wr_val        = merge_strb(32'h00000000, wdata_r, wstrb_r);

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			awaddr_r  <= '0;
			wdata_r   <= 32'h00000000;
			wstrb_r   <= 4'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= CISE_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_r <= 1'b1;
				wdata_r  <= s_axi_wdata;
				wstrb_r  <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold_r <= 1'b0;
				w_hold_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_hit ? CISE_RESP_OKAY : CISE_RESP_SLVERR;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h00000000;
			rresp_r  <= CISE_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_hit ? rd_val : 32'h00000000;
			rresp_r  <= rd_hit ? CISE_RESP_OKAY : CISE_RESP_SLVERR;
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// ==========================================================
	// Core state
	// ==========================================================
	cise_phase_e   phase_r;
	cise_instr_s   instr_r;
	logic          busy_r;
	logic          in_nop_r;
	logic [1:0]    nop_left_r;
	logic [1:0]    cyc_cnt_r;
	logic [1:0]    last_cyc_r;
	logic          soft_rst_r;
	logic [20:0]   pc_r;
	logic [7:0]    w_r;
	logic          flag_z_r;
	logic          flag_n_r;
	logic [3:0]    bank_r;
	logic [11:0]   idx_base_r;
	logic          ext_r;
	logic [20:0]   tos_r;
	logic [4:0]    depth_r;
	logic          ovf_r;
	logic [11:0]   fsel_r;
	logic [7:0]    alu_r;
	logic          zero_r;
	logic [7:0]    mem_rdata;
	logic [11:0]   op_addr;
	logic          mem_we;
	logic [11:0]   mem_waddr;
	logic [7:0]    mem_wdata;
	logic          is_reset;
	logic          is_xorl;
	logic          is_relative_subroutine_call;
	logic          is_tstfz;
	logic          is_bneg;
	logic          is_bclr;
	logic          commit;
	logic          start;
	logic [1:0]    extra;
	logic [20:0]   pc_plus2;
	logic [20:0]   pc_next;
	logic [7:0]    xor_res;

	assign is_reset = instr_r.word == CISE_OP_RESET;
	assign is_xorl  = instr_r.word[15:8] == CISE_OP_XORL;
	assign is_relative_subroutine_call = instr_r.word[15:11] == CISE_OP_RELATIVE_SUBROUTINE_CALL;
	assign is_tstfz = instr_r.word[15:9] == CISE_OP_TSTFZ;
	assign is_bneg  = instr_r.word[15:8] == CISE_OP_BNEG;
	assign is_bclr  = instr_r.word[15:12] == CISE_OP_BCLR;
	assign op_addr  = file_addr(instr_r.word[8], instr_r.word[7:0], bank_r, ext_r, idx_base_r);
	assign commit   = busy_r && !in_nop_r && phase_r == CISE_Q4;
	assign start    = wr_fire && awaddr_r == CISE_OFF_INSTR && !busy_r && !soft_rst_r;
	assign pc_plus2 = pc_r + CISE_PC_STEP;
	assign xor_res  = w_r ^ instr_r.word[7:0];

	always_comb begin
		extra   = 2'd0;
		pc_next = pc_plus2;
		if (is_relative_subroutine_call) begin
			extra   = 2'd1;
			pc_next = pc_plus2 + {{9{instr_r.word[10]}}, instr_r.word[10:0], 1'b0};
		end else if (is_bneg && flag_n_r) begin
			extra   = 2'd1;
			pc_next = pc_plus2 + {{12{instr_r.word[7]}}, instr_r.word[7:0], 1'b0};
		end else if (is_tstfz && zero_r) begin
			extra   = instr_r.next_two ? 2'd2 : 2'd1;
			pc_next = pc_plus2 + (instr_r.next_two ? 21'h000004 : CISE_PC_STEP);
		end
	end

	always_comb begin
		wr_hit = 1'b1;
		case (awaddr_r)
			CISE_OFF_CTRL, CISE_OFF_INSTR, CISE_OFF_PC, CISE_OFF_WREG, CISE_OFF_FLAGS, CISE_OFF_BANK,
			CISE_OFF_TOS, CISE_OFF_IDXBASE, CISE_OFF_FADDR, CISE_OFF_FDATA, CISE_OFF_EXEC: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_comb begin
		rd_hit = 1'b1;
		rd_val = 32'h00000000;
		case (s_axi_araddr)
			CISE_OFF_CTRL:    rd_val[CISE_CTRL_EXT_BIT] = ext_r;
			CISE_OFF_INSTR:   rd_val[16:0] = instr_r;
			CISE_OFF_PC:      rd_val[20:0] = pc_r;
			CISE_OFF_WREG:    rd_val[7:0] = w_r;
			CISE_OFF_FLAGS: begin
				rd_val[CISE_FLAG_Z_BIT] = flag_z_r;
				rd_val[CISE_FLAG_N_BIT] = flag_n_r;
			end
			CISE_OFF_BANK:    rd_val[3:0] = bank_r;
			CISE_OFF_TOS:     rd_val[20:0] = tos_r;
			CISE_OFF_IDXBASE: rd_val[11:0] = idx_base_r;
			CISE_OFF_FADDR:   rd_val[11:0] = fsel_r;
			CISE_OFF_FDATA:   rd_val = 32'h00000000;
			CISE_OFF_EXEC: begin
				rd_val[CISE_EXEC_BUSY_BIT] = busy_r;
				rd_val[CISE_EXEC_CYC_LSB +: 2] = last_cyc_r;
				rd_val[CISE_EXEC_OVF_BIT] = ovf_r;
				rd_val[CISE_EXEC_DEP_LSB +: 5] = depth_r;
			end
			default:          rd_hit = 1'b0;
		endcase
	end

	// ==========================================================
	// Phase sequencer and cycle accounting
	// ==========================================================
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			phase_r    <= CISE_Q1;
			busy_r     <= 1'b0;
			in_nop_r   <= 1'b0;
			nop_left_r <= 2'd0;
			cyc_cnt_r  <= 2'd0;
			last_cyc_r <= 2'd0;
			instr_r    <= '0;
		end else if (soft_rst_r) begin
			phase_r    <= CISE_Q1;
			busy_r     <= 1'b0;
			in_nop_r   <= 1'b0;
			nop_left_r <= 2'd0;
			cyc_cnt_r  <= 2'd0;
			last_cyc_r <= 2'd0;
		end else if (start) begin
			instr_r   <= wr_val[16:0];
			busy_r    <= 1'b1;
			phase_r   <= CISE_Q1;
			cyc_cnt_r <= 2'd1;
		end else if (busy_r) begin
			case (phase_r)
				CISE_Q1: phase_r <= CISE_Q2;
				CISE_Q2: phase_r <= CISE_Q3;
				CISE_Q3: phase_r <= CISE_Q4;
				CISE_Q4: phase_r <= CISE_Q1;
				default: phase_r <= CISE_Q1;
			endcase
			if (phase_r == CISE_Q4) begin
				if (!in_nop_r && extra == 2'd0) begin
					busy_r     <= 1'b0;
					last_cyc_r <= cyc_cnt_r;
				end else if (!in_nop_r) begin
					in_nop_r   <= 1'b1;
					nop_left_r <= extra;
					cyc_cnt_r  <= cyc_cnt_r + 2'd1;
				end else if (nop_left_r == 2'd1) begin
					busy_r     <= 1'b0;
					in_nop_r   <= 1'b0;
					last_cyc_r <= cyc_cnt_r;
				end else begin
					nop_left_r <= nop_left_r - 2'd1;
					cyc_cnt_r  <= cyc_cnt_r + 2'd1;
				end
			end
		end
	end

	// Reset opcode fires in its own Q4 and acts on the next edge, so the bus stays alive.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			soft_rst_r <= 1'b0;
		end else begin
			soft_rst_r <= commit && is_reset;
		end
	end

	// ==========================================================
	// Operand read and processing
	// ==========================================================
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			alu_r  <= CISE_BYTE_RST;
			zero_r <= 1'b0;
		end else if (busy_r && !in_nop_r && phase_r == CISE_Q3) begin
			zero_r <= mem_rdata == 8'h00;
			alu_r  <= mem_rdata & ~(8'h01 << instr_r.word[11:9]);
		end
	end

	// ==========================================================
	// Write-back: PC, W, flags, return stack
	// ==========================================================
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pc_r     <= CISE_PC_RST;
			w_r      <= CISE_BYTE_RST;
			flag_z_r <= 1'b0;
			flag_n_r <= 1'b0;
		end else if (soft_rst_r) begin
			pc_r     <= CISE_PC_RST;
			w_r      <= CISE_BYTE_RST;
			flag_z_r <= 1'b0;
			flag_n_r <= 1'b0;
		end else if (commit && !is_reset) begin
			pc_r <= pc_next;
			if (is_xorl) begin
				w_r      <= xor_res;
				flag_z_r <= xor_res == 8'h00;
				flag_n_r <= xor_res[7];
			end
		end else if (wr_fire && !busy_r) begin
			if (awaddr_r == CISE_OFF_PC) begin
				pc_r <= 21'(merge_strb({11'h000, pc_r}, wdata_r, wstrb_r) & 32'h001FFFFE);
			end
			if (awaddr_r == CISE_OFF_WREG) begin
				w_r <= 8'(merge_strb({24'h000000, w_r}, wdata_r, wstrb_r));
			end
			if (awaddr_r == CISE_OFF_FLAGS) begin
				flag_z_r <= wr_val[CISE_FLAG_Z_BIT];
				flag_n_r <= wr_val[CISE_FLAG_N_BIT];
			end
		end
	end

	// Only the push is modelled, so the stack keeps its top and its depth.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tos_r   <= CISE_PC_RST;
			depth_r <= 5'd0;
			ovf_r   <= 1'b0;
		end else if (soft_rst_r) begin
			tos_r   <= CISE_PC_RST;
			depth_r <= 5'd0;
			ovf_r   <= 1'b0;
		end else if (commit && is_relative_subroutine_call) begin
			tos_r <= pc_plus2;
			if (depth_r == 5'(STACK_DEPTH)) begin
				ovf_r <= 1'b1;
			end else begin
				depth_r <= depth_r + 5'd1;
			end
		end
	end

	// ==========================================================
	// Addressing configuration
	// ==========================================================
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bank_r     <= CISE_BANK_RST;
			idx_base_r <= CISE_IDX_RST;
			fsel_r     <= 12'h000;
		end else if (soft_rst_r) begin
			bank_r     <= CISE_BANK_RST;
			idx_base_r <= CISE_IDX_RST;
			fsel_r     <= 12'h000;
		end else if (wr_fire && !busy_r) begin
			if (awaddr_r == CISE_OFF_BANK) begin
				bank_r <= wr_val[3:0];
			end
			if (awaddr_r == CISE_OFF_IDXBASE) begin
				idx_base_r <= wr_val[11:0];
			end
			if (awaddr_r == CISE_OFF_FADDR) begin
				fsel_r <= wr_val[11:0];
			end
		end
	end

	// The configuration bit is not a core register, so the reset opcode leaves it alone.
	always_ff @(posedge sys_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ext_r <= CISE_EXT_RST;
		end else if (wr_fire && !busy_r && awaddr_r == CISE_OFF_CTRL) begin
			ext_r <= wr_val[CISE_CTRL_EXT_BIT];
		end
	end

	// ==========================================================
	// File memory
	// ==========================================================
	assign mem_we    = (commit && is_bclr) || (wr_fire && !busy_r && awaddr_r == CISE_OFF_FDATA);
	assign mem_waddr = busy_r ? op_addr : fsel_r;
	assign mem_wdata = busy_r ? alu_r : wr_val[7:0];

	cise_data_mem #(
		.ADDR_W (CISE_FADDR_W),
		.DATA_W (8)
	) u_mem (
		.sys_clk_i (sys_clk_i),
		.we_i      (mem_we),
		.waddr_i   (mem_waddr),
		.wdata_i   (mem_wdata),
		.raddr_i   (op_addr),
		.rdata_o   (mem_rdata)
	);

endmodule

`default_nettype wire

/* File: logic/cise_data_mem.sv */
`timescale 1ns/1ps
`default_nettype none

module cise_data_mem #(
	parameter int ADDR_W = 12,
	parameter int DATA_W = 8
) (
	input  wire logic              sys_clk_i,
	input  wire logic              we_i,
	input  wire logic [ADDR_W-1:0] waddr_i,
	input  wire logic [DATA_W-1:0] wdata_i,
	input  wire logic [ADDR_W-1:0] raddr_i,
	output logic      [DATA_W-1:0] rdata_o
);

	if (ADDR_W < 1 || ADDR_W > 16 || DATA_W < 1) begin : g_bad_size
		$error("cise_data_mem: unsupported size");
	end

	logic [DATA_W-1:0] mem_r [0:(1<<ADDR_W)-1];

	// Contents survive every reset, like the file registers of the core.
	always_ff @(posedge sys_clk_i) begin
		if (we_i) begin
			mem_r[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		rdata_o <= mem_r[raddr_i];
	end

endmodule

`default_nettype wire

/* File: sim/cise_core_props.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Register port handshake checks
// ==========================================================
module cise_core_props
	import cise_pkg::*;
#(
	parameter int STACK_DEPTH = 8
) (
	input wire logic                   sys_clk_i,
	input wire logic                   resetn_i,
	input wire logic [CISE_AXI_AW-1:0] s_axi_awaddr,
	input wire logic                   s_axi_awvalid,
	input wire logic                   s_axi_awready,
	input wire logic [31:0]            s_axi_wdata,
	input wire logic [3:0]             s_axi_wstrb,
	input wire logic                   s_axi_wvalid,
	input wire logic                   s_axi_wready,
	input wire logic [1:0]             s_axi_bresp,
	input wire logic                   s_axi_bvalid,
	input wire logic                   s_axi_bready,
	input wire logic [CISE_AXI_AW-1:0] s_axi_araddr,
	input wire logic                   s_axi_arvalid,
	input wire logic                   s_axi_arready,
	input wire logic [31:0]            s_axi_rdata,
	input wire logic [1:0]             s_axi_rresp,
	input wire logic                   s_axi_rvalid,
	input wire logic                   s_axi_rready
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before accept");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before accept");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	rd_quiet_a: assert property (!s_axi_rvalid && !(s_axi_arvalid && s_axi_arready) |=> !s_axi_rvalid)
		else $error("read answer without request");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while answer pending");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response not two cycles after take");
	b_release_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not released");
	r_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer not released");

	wr_seen_c: cover property (s_axi_bvalid && s_axi_bready);
	rd_seen_c: cover property (s_axi_rvalid && s_axi_rready);
	rd_err_c: cover property (s_axi_rvalid && s_axi_rresp == CISE_RESP_SLVERR);
endmodule

bind cise_core cise_core_props #(.STACK_DEPTH(STACK_DEPTH)) props_i (
	.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready));

`default_nettype wire

/* File: sim/cise_core_test.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end

module cise_core_test;
	import cise_pkg::*;

	logic                   sys_clk_i;
	logic                   resetn_i;
	logic [CISE_AXI_AW-1:0] awaddr;
	logic [CISE_AXI_AW-1:0] araddr;
	logic [31:0]            wdata;
	logic [31:0]            rdata;
	logic [31:0]            rd_v;
	logic [3:0]             wstrb;
	logic [1:0]             bresp;
	logic [1:0]             rresp;
	logic [1:0]             rs;
	logic                   awvalid;
	logic                   awready;
	logic                   wvalid;
	logic                   wready;
	logic                   bvalid;
	logic                   bready;
	logic                   arvalid;
	logic                   arready;
	logic                   rvalid;
	logic                   rready;
	int                     n_fail;
	int                     total_checks;

	cise_core dut (
		.sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end

	// ==========================================================
	// Bus tasks
	// ==========================================================
	// Ready is raised together with the address and data, so the answer is taken at the first edge that shows it.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ad;
		logic wd;
		ad = 1'b0;
		wd = 1'b0;
		@(posedge sys_clk_i);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk_i);
			if (!ad && awready) begin
				ad = 1'b1;
				awvalid <= 1'b0;
			end
			if (!wd && wready) begin
				wd = 1'b1;
				wvalid <= 1'b0;
			end
		end while (bvalid !== 1'b1);
		`CHK(bresp, CISE_RESP_OKAY)
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		logic ad;
		ad = 1'b0;
		@(posedge sys_clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk_i);
			if (!ad && arready) begin
				ad = 1'b1;
				arvalid <= 1'b0;
			end
		end while (rvalid !== 1'b1);
		rd_v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask

	task automatic ck(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		`CHK(rd_v, e)
	endtask

	// Leaves the final EXEC word in rd_v.
	task automatic run(input logic [31:0] i);
		int k;
		k = 0;
		wr(CISE_OFF_INSTR, i);
		do begin
			rd(CISE_OFF_EXEC);
			k++;
		end while (rd_v[0] !== 1'b0 && k < 10);
		`CHK(rd_v[0], 1'b0)
	endtask

	task automatic fw(input logic [31:0] a, input logic [31:0] d);
		wr(CISE_OFF_FADDR, a);
		wr(CISE_OFF_FDATA, d);
	endtask

	task automatic sk(input logic [31:0] x, input logic [31:0] i, input logic [31:0] pc, input logic [1:0] c);
		wr(CISE_OFF_CTRL, x);
		wr(CISE_OFF_PC, 32'h300);
		run(i);
		`CHK(rd_v[2:1], c)
		ck(CISE_OFF_PC, pc);
	endtask

	task automatic final_report();
		if (n_fail == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	localparam logic [7:0] ROFF [7] = '{CISE_OFF_PC, CISE_OFF_WREG, CISE_OFF_FLAGS, CISE_OFF_BANK,
		CISE_OFF_TOS, CISE_OFF_IDXBASE, CISE_OFF_EXEC};

	initial begin
		repeat (20000) @(posedge sys_clk_i);
		n_fail++;
		$display("MISMATCH t=%0t watchdog expired", $time);
		final_report();
	end

	// ==========================================================
	// Test sequence
	// ==========================================================
	initial begin
		n_fail = 0;
		total_checks = 0;
		resetn_i = 1'b0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		repeat (8) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		wstrb <= 4'hF;
		ck(CISE_OFF_CTRL, 32'h0);
		for (int i = 0; i < 7; i++) ck(ROFF[i], 32'h0);
		rd(8'h30);
		`CHK(rs, CISE_RESP_SLVERR)
		wr(CISE_OFF_TOS, 32'h123);
		ck(CISE_OFF_TOS, 32'h0);
		wr(CISE_OFF_WREG, 32'hB5);
		run(32'h0AAF);
		`CHK(rd_v[2:1], 2'h1)
		ck(CISE_OFF_WREG, 32'h1A);
		ck(CISE_OFF_FLAGS, 32'h0);
		run(32'h0A1A);
		ck(CISE_OFF_FLAGS, 32'h1);
		run(32'h0A80);
		ck(CISE_OFF_WREG, 32'h80);
		ck(CISE_OFF_FLAGS, 32'h2);
		ck(CISE_OFF_PC, 32'h6);
		wr(CISE_OFF_PC, 32'h1000);
		run(32'hDC00);
		`CHK(rd_v[2:1], 2'h2)
		`CHK(rd_v[8:4], 5'h01)
		ck(CISE_OFF_PC, 32'h802);
		ck(CISE_OFF_TOS, 32'h1002);
		run(32'hDBFF);
		ck(CISE_OFF_PC, 32'h1002);
		ck(CISE_OFF_TOS, 32'h804);
		wr(CISE_OFF_PC, 32'h200);
		run(32'hE6FF);
		`CHK(rd_v[2:1], 2'h2)
		ck(CISE_OFF_PC, 32'h200);
		wr(CISE_OFF_FLAGS, 32'h0);
		run(32'hE67F);
		`CHK(rd_v[2:1], 2'h1)
		ck(CISE_OFF_PC, 32'h202);
		fw(32'h210, 32'h0);
		fw(32'h020, 32'h5);
		fw(32'h420, 32'h0);
		fw(32'h45F, 32'h0);
		fw(32'h05F, 32'h9);
		fw(32'hF60, 32'h0);
		wr(CISE_OFF_BANK, 32'h2);
		wr(CISE_OFF_IDXBASE, 32'h400);
		sk(32'h0, 32'h6710, 32'h304, 2'h2);
		sk(32'h0, 32'h16710, 32'h306, 2'h3);
		sk(32'h0, 32'h6620, 32'h302, 2'h1);
		sk(32'h1, 32'h6620, 32'h304, 2'h2);
		sk(32'h1, 32'h665F, 32'h304, 2'h2);
		sk(32'h0, 32'h665F, 32'h302, 2'h1);
		sk(32'h1, 32'h6660, 32'h304, 2'h2);
		fw(32'h211, 32'h10);
		run(32'h9911);
		sk(32'h1, 32'h6711, 32'h304, 2'h2);
		run(32'h00FF);
		for (int i = 0; i < 7; i++) ck(ROFF[i], 32'h0);
		ck(CISE_OFF_CTRL, 32'h1);
		final_report();
	end
endmodule

`default_nettype wire
